//--- design/guard_pkg.sv
/*
 * Shared constants for the protected register write guard: register
 * indices, reset values, wait-state figures and the access state machine.
 * Assumes a 32-bit AXI4-Lite register bus where byte address = 4 * index.
 */
`default_nettype none

package guard_pkg;

    // register indices (byte address is four times the index)
    localparam logic [27:0] WAIT_CTRL_IDX         = 28'hFFFF06E;
    localparam logic [27:0] PROT_CMD_IDX          = 28'hFFFF1FC;
    localparam logic [27:0] SYS_STATUS_IDX        = 28'hFFFF802;

    // protected register window
    localparam logic [27:0] PROT_LO_IDX           = 28'hFFFF0C0;
    localparam logic [27:0] PROT_HI_IDX           = 28'hFFFF0FF;

    // peripheral registers with extra wait cycles
    localparam logic [27:0] TIMER_P_COUNT_IDX     = 28'hFFFF5A0;
    localparam logic [27:0] TIMER_P_COMPARE_IDX   = 28'hFFFF5A1;
    localparam logic [27:0] TIMER_Q_COUNT_IDX     = 28'hFFFF5B0;
    localparam logic [27:0] TIMER_Q_COMPARE_IDX   = 28'hFFFF5B1;
    localparam logic [27:0] RT_BUFFER_LOW_IDX     = 28'hFFFF6A0;
    localparam logic [27:0] RT_BUFFER_HIGH_IDX    = 28'hFFFF6A1;
    localparam logic [27:0] WATCHDOG_MODE_IDX     = 28'hFFFF6D0;
    localparam logic [27:0] SERIAL_BUS_STATUS_IDX = 28'hFFFFD86;
    localparam logic [27:0] ADC_MODE_IDX          = 28'hFFFF200;
    localparam logic [27:0] ADC_RESULT_IDX        = 28'hFFFF210;
    localparam logic [27:0] CRC_DATA_INPUT_IDX    = 28'hFFFF310;

    // reset values and field positions
    localparam logic [7:0]  WAIT_CTRL_RESET       = 8'h77;
    localparam logic [7:0]  SYS_STATUS_RESET      = 8'h00;
    localparam int          PROT_ERR_BIT          = 0;

    // access timing in CPU clocks: BASE + i + j + (J_BASE + j) * k
    localparam logic [7:0]  BASE_ACCESS_CLKS      = 8'h03;
    localparam logic [7:0]  WAIT_J_BASE           = 8'h02;
    localparam logic [2:0]  K_SYNC_READ           = 3'h1;
    localparam logic [2:0]  K_CMP_BURST           = 3'h3;
    localparam logic [2:0]  K_RT_BUFFER           = 3'h1;
    localparam logic [2:0]  K_WATCHDOG            = 3'h3;
    localparam logic [2:0]  K_SERIAL_STATUS       = 3'h1;
    localparam logic [2:0]  K_CRC                 = 3'h1;

    localparam logic [1:0]  RESP_OKAY             = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_WRESP,
        ST_RRESP
    } state_e;

endpackage

`default_nettype wire

//--- design/protected_register_write_guard.sv
/*
 * Protected register write guard with peripheral wait-state insertion,
 * reached as an AXI4-Lite slave. Peripheral accesses are forwarded on a
 * simple strobe port, registered one clock after the access is taken; peripheral-side levels arrive
 * asynchronously and are synchronised here.
 */
// Contract
// - command register is 8-bit write-only; reads return junk and change nothing.
// - protected write accepted only as first write after a command write.
// - command write value is ignored; only the write itself arms.
// - status register is byte/bit accessible and resets to zero.
// - protected write without arming sets error and is dropped.
// - first write after arming to unprotected register sets error.
// - reads between arming and protected write neither flag nor disarm.
// - error flag stays set until written 0 or reset.
// - writing 0 to the flag right after arming leaves it cleared.
// - two command writes back to back set the error flag.
// - wait-control register is byte read/write, resets to 77H.
// - peripheral access takes three clocks plus configured waits.
// - CPU access is stalled until the peripheral transfer is correct.
// - timer count/compare reads add 1 or 2; back-to-back compare writes 3 or 4.
// - real-time buffer writes while output disabled add 1 wait.
// - watchdog mode write while running adds 3 waits.
// - serial status read and CRC write add 1; ADC reads add 1 or 2.
`timescale 1ns/1ps
`default_nettype none

module protected_register_write_guard
    import guard_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] awaddr_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    output logic [1:0]       bresp_out,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    input  wire logic [31:0] araddr_in,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             periph_wr_out,
    output logic             periph_rd_out,
    output logic [31:0]      periph_addr_out,
    output logic [31:0]      periph_wdata_out,
    output logic [3:0]       periph_wstrb_out,
    input  wire logic [31:0] periph_rdata_in,
    input  wire logic        periph_clk_in,
    input  wire logic        watchdog_running_in,
    input  wire logic        rt_output_enable_in,
    output logic             protect_error_flag_out,
    output logic             armed_out
);

    typedef struct packed {
        state_e      st;
        logic        aw_have;
        logic        w_have;
        logic [31:0] addr;
        logic [31:0] raddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        is_write;
        logic        own_rd;
        logic [7:0]  cnt;
        logic [7:0]  wait_ctrl;
        logic        err;
        logic        armed;
        logic        last_cmp_wr;
        logic [2:0]  sq1;
        logic [2:0]  sq2;
        logic [2:0]  sq3;
        logic [2:0]  stable;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic        pwr;
        logic        prd;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pwstrb;
    } guard_s;

    guard_s r_reg;
    guard_s r_next;

    // stable[0] peripheral clock phase, [1] watchdog running, [2] rt output enable
    logic [2:0] raw_async;
    assign raw_async = {rt_output_enable_in, watchdog_running_in, periph_clk_in};

    function automatic logic is_compare(input logic [27:0] idx);
        is_compare = (idx == TIMER_P_COMPARE_IDX) || (idx == TIMER_Q_COMPARE_IDX);
    endfunction

    // extra peripheral-clock multiples k for this access
    function automatic logic [2:0] extra_k(
        input logic [27:0] idx,
        input logic        wr,
        input logic        phase,
        input logic        wdt_run,
        input logic        rt_en,
        input logic        last_cmp
    );
        logic [2:0] ph;
        ph = {2'h0, phase};
        extra_k = 3'h0;
        if (!wr) begin
            if ((idx == TIMER_P_COUNT_IDX) || (idx == TIMER_Q_COUNT_IDX) ||
                is_compare(idx)) begin
                extra_k = K_SYNC_READ + ph;
            end else if (idx == SERIAL_BUS_STATUS_IDX) begin
                extra_k = K_SERIAL_STATUS;
            end else if ((idx == ADC_MODE_IDX) || (idx == ADC_RESULT_IDX)) begin
                extra_k = K_SYNC_READ + ph;
            end
        end else begin
            if (is_compare(idx) && last_cmp) begin
                extra_k = K_CMP_BURST + ph;
            end else if (((idx == RT_BUFFER_LOW_IDX) || (idx == RT_BUFFER_HIGH_IDX)) &&
                         !rt_en) begin
                extra_k = K_RT_BUFFER;
            end else if ((idx == WATCHDOG_MODE_IDX) && wdt_run) begin
                extra_k = K_WATCHDOG;
            end else if (idx == CRC_DATA_INPUT_IDX) begin
                extra_k = K_CRC;
            end
        end
    endfunction

    // total access clocks: 3 + i + j + (2 + j) * k
    // own registers pay it too
    function automatic logic [7:0] access_clks(
        input logic [7:0] wctrl,
        input logic [2:0] k
    );
        logic [7:0] i_w;
        logic [7:0] j_w;
        logic [7:0] per_k;
        i_w = {4'h0, wctrl[7:4]};
        j_w = {4'h0, wctrl[3:0]};
        per_k = (WAIT_J_BASE + j_w) * {5'h00, k};
        access_clks = BASE_ACCESS_CLKS + i_w + j_w + per_k;
    endfunction

    always_comb begin
        logic [27:0] idx;
        logic [2:0]  k;
        logic        clearing;
        idx = 28'h0000000;
        k = 3'h0;
        clearing = 1'b0;
        r_next = r_reg;
        r_next.pwr = 1'b0;
        r_next.prd = 1'b0;
        // no decode errors
        r_next.bresp = RESP_OKAY;
        r_next.rresp = RESP_OKAY;

        // 3-flop synchronisers; a level counts once stages 2 and 3 agree
        r_next.sq1 = raw_async;
        r_next.sq2 = r_reg.sq1;
        r_next.sq3 = r_reg.sq2;
        for (int b = 0; b < 3; b++) begin
            if (r_reg.sq2[b] == r_reg.sq3[b]) begin
                r_next.stable[b] = r_reg.sq3[b];
            end
        end

        // address and data are taken independently, in either order
        if (awvalid_in && r_reg.awready) begin
            r_next.aw_have = 1'b1;
            r_next.addr = awaddr_in;
        end
        if (wvalid_in && r_reg.wready) begin
            r_next.w_have = 1'b1;
            r_next.wdata = wdata_in;
            r_next.wstrb = wstrb_in;
        end

        case (r_reg.st)
            ST_IDLE: begin
                // write first if both ready; arready stays low while a whole write is held
                if (arvalid_in && r_reg.arready) begin
                    // reads never touch the armed state or the flag
                    idx = araddr_in[29:2];
                    k = extra_k(idx, 1'b0, r_reg.stable[0], r_reg.stable[1],
                                r_reg.stable[2], r_reg.last_cmp_wr);
                    r_next.raddr = araddr_in;
                    r_next.is_write = 1'b0;
                    r_next.st = ST_BUSY;
                    r_next.cnt = access_clks(r_reg.wait_ctrl, k) - 8'h01;
                    r_next.last_cmp_wr = 1'b0;
                    r_next.own_rd = 1'b1;
                    if (idx == PROT_CMD_IDX) begin
                        r_next.rdata = 32'h00000000;
                    end else if (idx == SYS_STATUS_IDX) begin
                        r_next.rdata = {31'h00000000, r_reg.err};
                    end else if (idx == WAIT_CTRL_IDX) begin
                        r_next.rdata = {24'h000000, r_reg.wait_ctrl};
                    end else begin
                        r_next.own_rd = 1'b0;
                        r_next.prd = 1'b1;
                        r_next.paddr = araddr_in;
                    end
                end else if (r_reg.aw_have && r_reg.w_have) begin
                    idx = r_reg.addr[29:2];
                    k = extra_k(idx, 1'b1, r_reg.stable[0], r_reg.stable[1],
                                r_reg.stable[2], r_reg.last_cmp_wr);
                    r_next.is_write = 1'b1;
                    r_next.st = ST_BUSY;
                    r_next.cnt = access_clks(r_reg.wait_ctrl, k) - 8'h01;
                    r_next.last_cmp_wr = is_compare(idx);
                    r_next.armed = 1'b0;
                    if (idx == PROT_CMD_IDX) begin
                        // value is a dummy; only the write arms
                        if (r_reg.armed) begin
                            r_next.err = 1'b1;
                        end else begin
                            r_next.armed = 1'b1;
                        end
                    end else if (idx == SYS_STATUS_IDX) begin
                        // only the flag bit is writable, and only to clear it
                        clearing = r_reg.wstrb[0] && !r_reg.wdata[PROT_ERR_BIT];
                        if (clearing) begin
                            r_next.err = 1'b0;
                        end else if (r_reg.armed) begin
                            r_next.err = 1'b1;
                        end
                    end else if ((idx >= PROT_LO_IDX) && (idx <= PROT_HI_IDX)) begin
                        if (r_reg.armed) begin
                            r_next.pwr = 1'b1;
                            r_next.paddr = r_reg.addr;
                            r_next.pwdata = r_reg.wdata;
                            r_next.pwstrb = r_reg.wstrb;
                        end else begin
                            r_next.err = 1'b1;
                        end
                    end else begin
                        if (r_reg.armed) begin
                            r_next.err = 1'b1;
                        end
                        if (idx == WAIT_CTRL_IDX) begin
                            if (r_reg.wstrb[0]) begin
                                r_next.wait_ctrl = r_reg.wdata[7:0];
                            end
                        end else begin
                            r_next.pwr = 1'b1;
                            r_next.paddr = r_reg.addr;
                            r_next.pwdata = r_reg.wdata;
                            r_next.pwstrb = r_reg.wstrb;
                        end
                    end
                end
            end
            ST_BUSY: begin
                // cpu stalls here until the peripheral transfer has settled
                r_next.cnt = r_reg.cnt - 8'h01;
                // sample data at the last wait
                if (r_reg.cnt == 8'h01) begin
                    if (r_reg.is_write) begin
                        r_next.bvalid = 1'b1;
                        r_next.st = ST_WRESP;
                    end else begin
                        r_next.rvalid = 1'b1;
                        r_next.st = ST_RRESP;
                        if (!r_reg.own_rd) begin
                            r_next.rdata = periph_rdata_in;
                        end
                    end
                end
            end
            ST_WRESP: begin
                if (bready_in) begin
                    r_next.bvalid = 1'b0;
                    r_next.aw_have = 1'b0;
                    r_next.w_have = 1'b0;
                    r_next.st = ST_IDLE;
                end
            end
            ST_RRESP: begin
                if (rready_in) begin
                    r_next.rvalid = 1'b0;
                    r_next.st = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        // ready flags registered so they come straight from flops
        r_next.awready = !r_next.aw_have;
        r_next.wready = !r_next.w_have;
        r_next.arready = (r_next.st == ST_IDLE) && !(r_next.aw_have && r_next.w_have);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.wait_ctrl <= WAIT_CTRL_RESET;
            r_reg.err <= SYS_STATUS_RESET[PROT_ERR_BIT];
        end else begin
            r_reg <= r_next;
        end
    end

    assign awready_out = r_reg.awready;
    assign wready_out = r_reg.wready;
    assign bvalid_out = r_reg.bvalid;
    assign bresp_out = r_reg.bresp;
    assign arready_out = r_reg.arready;
    assign rvalid_out = r_reg.rvalid;
    assign rdata_out = r_reg.rdata;
    assign rresp_out = r_reg.rresp;
    assign periph_wr_out = r_reg.pwr;
    assign periph_rd_out = r_reg.prd;
    assign periph_addr_out = r_reg.paddr;
    assign periph_wdata_out = r_reg.pwdata;
    assign periph_wstrb_out = r_reg.pwstrb;
    assign protect_error_flag_out = r_reg.err;
    assign armed_out = r_reg.armed;

endmodule

`default_nettype wire

//--- tb/guard_checker.sv
/*
 * Concurrent checks on the protected register write guard's ports.
 * Assumes it is bound to the guard's top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module guard_checker
    import guard_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        awvalid_in,
    input wire logic        awready_out,
    input wire logic [31:0] awaddr_in,
    input wire logic        wvalid_in,
    input wire logic        wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0]  wstrb_in,
    input wire logic        bvalid_out,
    input wire logic        arvalid_in,
    input wire logic        arready_out,
    input wire logic        rvalid_out,
    input wire logic        periph_wr_out,
    input wire logic [31:0] periph_addr_out,
    input wire logic        protect_error_flag_out,
    input wire logic        armed_out
);
    logic [27:0] last_idx_reg;
    logic        last_clr_reg;
    wire logic   in_win = periph_addr_out[29:2] >= PROT_LO_IDX &&
                          periph_addr_out[29:2] <= PROT_HI_IDX;

    // last taken write, so a flag change can be traced to its cause
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_idx_reg <= 28'h0000000;
            last_clr_reg <= 1'b0;
        end else begin
            if (awvalid_in && awready_out) last_idx_reg <= awaddr_in[29:2];
            if (wvalid_in && wready_out) last_clr_reg <= wstrb_in[0] && !wdata_in[0];
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_fwd_needs_arm: assert property (periph_wr_out && in_win |-> $past(armed_out))
        else $error("protected write forwarded while not armed");
    a_fwd_disarms: assert property (periph_wr_out |-> !armed_out)
        else $error("armed state survives a forwarded write");
    a_read_quiet: assert property (arvalid_in && arready_out |->
        ##1 ($stable(armed_out) && $stable(protect_error_flag_out)) [*3])
        else $error("read changed armed state or error flag");
    a_flag_rise: assert property ($rose(protect_error_flag_out) |->
        $past(armed_out) || (last_idx_reg >= PROT_LO_IDX && last_idx_reg <= PROT_HI_IDX))
        else $error("error flag set without a sequence fault");
    a_flag_fall: assert property ($fell(protect_error_flag_out) |->
        last_idx_reg == SYS_STATUS_IDX && last_clr_reg)
        else $error("error flag cleared without a zero write");
    a_read_wait: assert property (arvalid_in && arready_out |=>
        !rvalid_out [*2] ##[1:120] rvalid_out)
        else $error("read answer outside the access window");
    a_write_wait: assert property (awvalid_in && awready_out && wvalid_in && wready_out |=>
        !bvalid_out [*3] ##[1:130] bvalid_out)
        else $error("write answer outside the access window");
    a_bus_stall: assert property (bvalid_out |-> !awready_out && !wready_out && !arready_out)
        else $error("new access taken while a write answer is pending");
endmodule

bind protected_register_write_guard guard_checker guard_checker_i (
    .ref_clk_in, .rst_n_in, .awvalid_in, .awready_out, .awaddr_in, .wvalid_in, .wready_out,
    .wdata_in, .wstrb_in, .bvalid_out, .arvalid_in, .arready_out, .rvalid_out, .periph_wr_out,
    .periph_addr_out, .protect_error_flag_out, .armed_out);

`default_nettype wire

//--- tb/periph_model.sv
/*
 * Peripheral bus model: free-running bus clock and a small word store.
 * Assumes the guard's one-cycle forward strobes and held address.
 */
`timescale 1ns/1ps
`default_nettype none

module periph_model (
    input  wire logic        ref_clk_in,
    input  wire logic        periph_wr_in,
    input  wire logic        periph_rd_in,
    input  wire logic [31:0] periph_addr_in,
    input  wire logic [31:0] periph_wdata_in,
    output logic             periph_clk_out,
    output logic [31:0]      periph_rdata_out
);
    logic [31:0] store_reg [16];
    int          wr_count;

    initial begin
        periph_clk_out = 1'b0;
        periph_rdata_out = 32'h00000000;
        wr_count = 0;
        foreach (store_reg[n]) store_reg[n] = 32'h00000000;
    end

    // unrelated in phase, so both settings of the slower wait cases occur
    always #7.3 periph_clk_out = ~periph_clk_out;

    always @(posedge ref_clk_in) begin
        if (periph_wr_in) begin
            store_reg[periph_addr_in[5:2]] <= periph_wdata_in;
            wr_count <= wr_count + 1;
        end
        if (periph_rd_in) periph_rdata_out <= store_reg[periph_addr_in[5:2]];
        else if (periph_wr_in) periph_rdata_out <= ~periph_rdata_out;
    end
endmodule

`default_nettype wire

//--- tb/protected_register_write_guard_tb.sv
/*
 * Self-checking bench for the protected register write guard.
 * Assumes guard_pkg, the guard, its bound checker and periph_model.
 */
`timescale 1ns/1ps
`default_nettype none

module protected_register_write_guard_tb
    import guard_pkg::*;
;
    logic        ref_clk_in = 1'b0, rst_n_in = 1'b0;
    logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
    logic        arvalid_in = 1'b0, rready_in = 1'b0;
    logic [31:0] awaddr_in = 32'h00000000, wdata_in = 32'h00000000, araddr_in = 32'h00000000;
    logic [3:0]  wstrb_in = 4'hF;
    logic        watchdog_running_in = 1'b1, rt_output_enable_in = 1'b0;
    logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, periph_clk_in;
    logic        periph_wr_out, periph_rd_out, protect_error_flag_out, armed_out;
    logic [31:0] rdata_out, periph_addr_out, periph_wdata_out, periph_rdata_in, rd;
    logic [1:0]  bresp_out, rresp_out;
    logic [7:0]  wc = 8'h77;
    int          fails = 0, comparisons = 0, lat;
    logic [27:0] ex_idx [10] = '{TIMER_P_COUNT_IDX, TIMER_Q_COMPARE_IDX, ADC_MODE_IDX,
        ADC_RESULT_IDX, SERIAL_BUS_STATUS_IDX, CRC_DATA_INPUT_IDX, RT_BUFFER_LOW_IDX,
        WATCHDOG_MODE_IDX, TIMER_P_COMPARE_IDX, TIMER_P_COMPARE_IDX};
    logic [9:0]  ex_wr = 10'b1111100000;
    int          ex_klo [10] = '{1, 1, 1, 1, 1, 1, 1, 3, 0, 3};
    int          ex_khi [10] = '{2, 2, 2, 2, 1, 1, 1, 3, 0, 4};

    always #2.5 ref_clk_in = ~ref_clk_in;

    protected_register_write_guard protected_register_write_guard_i (
        .ref_clk_in, .rst_n_in, .awvalid_in, .awready_out, .awaddr_in, .wvalid_in,
        .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in, .bresp_out,
        .arvalid_in, .arready_out, .araddr_in, .rvalid_out, .rready_in, .rdata_out,
        .rresp_out, .periph_wr_out, .periph_rd_out, .periph_addr_out, .periph_wdata_out,
        .periph_wstrb_out(), .periph_rdata_in, .periph_clk_in, .watchdog_running_in,
        .rt_output_enable_in, .protect_error_flag_out, .armed_out);

    periph_model periph_model_i (.ref_clk_in, .periph_wr_in(periph_wr_out),
        .periph_rd_in(periph_rd_out), .periph_addr_in(periph_addr_out),
        .periph_wdata_in(periph_wdata_out), .periph_clk_out(periph_clk_in),
        .periph_rdata_out(periph_rdata_in));

    function automatic int t_of(input int k);
        return 3 + int'(wc[7:4]) + int'(wc[3:0]) + (2 + int'(wc[3:0])) * k;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
            fails++;
        end
    endtask

    task automatic st(input logic a, input logic f);
        check("armed", {31'h00000000, a}, {31'h00000000, armed_out});
        check("error flag", {31'h00000000, f}, {31'h00000000, protect_error_flag_out});
    endtask

    // lat ends as edges from the later handshake to the raising of bvalid
    task automatic wr(input logic [27:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        lat = 0;
        awaddr_in <= {2'h0, idx, 2'h0};
        wdata_in <= d;
        wstrb_in <= s;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (!awvalid_in && !wvalid_in) lat++;
            if (awready_out) awvalid_in <= 1'b0;
            if (wready_out) wvalid_in <= 1'b0;
        end while (!bvalid_out && n < 300);
        check("bresp", 32'(RESP_OKAY), 32'(bresp_out));
        bready_in <= 1'b0;
        lat = lat - 1;
        if (n >= 300) fails++;
    endtask

    task automatic rdx(input logic [27:0] idx);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        lat = 0;
        araddr_in <= {2'h0, idx, 2'h0};
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (!arvalid_in) lat++;
            if (arready_out) arvalid_in <= 1'b0;
        end while (!rvalid_out && n < 300);
        rd = rdata_out;
        check("rresp", 32'(RESP_OKAY), 32'(rresp_out));
        rready_in <= 1'b0;
        if (n >= 300) fails++;
    endtask

    task automatic do_reset();
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        wc = 8'h77;
    endtask

    task automatic t_reset_vals();
        rdx(WAIT_CTRL_IDX);
        check("wait ctrl", 32'h00000077, rd);
        check("read time", t_of(0), lat);
        rdx(SYS_STATUS_IDX);
        check("status", 32'h00000000, rd);
        rdx(PROT_CMD_IDX);
        st(1'b0, 1'b0);
    endtask

    task automatic t_base_wait();
        wr(WAIT_CTRL_IDX, 32'h00000000);
        wc = 8'h00;
        rdx(WAIT_CTRL_IDX);
        check("wait ctrl", 32'h00000000, rd);
        check("read time", t_of(0), lat);
        wr(28'h0000010, 32'hA5A51234);
        check("write time", t_of(0), lat);
        rdx(28'h0000010);
        check("forwarded data", 32'hA5A51234, rd);
        wr(WAIT_CTRL_IDX, 32'h00000001);
        wc = 8'h01;
        rdx(28'h0000010);
        check("read time", t_of(0), lat);
    endtask

    // slow cases depend on the peripheral clock phase, so either figure is accepted
    task automatic t_extra_wait();
        logic [31:0] lo;
        logic [31:0] hi;
        for (int n = 0; n < 10; n++) begin
            if (ex_wr[n]) wr(ex_idx[n], 32'h00000055);
            else rdx(ex_idx[n]);
            lo = t_of(ex_klo[n]);
            hi = t_of(ex_khi[n]);
            check("access time", (lat == hi) ? hi : lo, lat);
        end
        rt_output_enable_in <= 1'b1;
        watchdog_running_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        wr(RT_BUFFER_HIGH_IDX, 32'h00000055);
        check("access time", t_of(0), lat);
        wr(WATCHDOG_MODE_IDX, 32'h00000055);
        check("access time", t_of(0), lat);
    endtask

    task automatic t_good_seq();
        int cnt;
        for (int n = 0; n < 2; n++) begin
            cnt = periph_model_i.wr_count;
            wr(PROT_CMD_IDX, n ? 32'h000000FF : 32'h00000000);
            st(1'b1, 1'b0);
            rdx(28'h0000010);
            st(1'b1, 1'b0);
            wr(n ? PROT_HI_IDX : PROT_LO_IDX, 32'h0000005A);
            st(1'b0, 1'b0);
            check("forwarded writes", cnt + 1, periph_model_i.wr_count);
        end
        cnt = periph_model_i.wr_count;
        wr(PROT_LO_IDX, 32'h0000005A);
        st(1'b0, 1'b1);
        check("forwarded writes", cnt, periph_model_i.wr_count);
        wr(SYS_STATUS_IDX, 32'h00000001);
        wr(SYS_STATUS_IDX, 32'h00000000, 4'h0);
        rdx(SYS_STATUS_IDX);
        check("status", 32'h00000001, rd);
        wr(SYS_STATUS_IDX, 32'h00000000);
        st(1'b0, 1'b0);
    endtask

    task automatic t_wrong_target();
        wr(PROT_CMD_IDX, 32'h00000011);
        wr(28'h0000010, 32'h00000022);
        st(1'b0, 1'b1);
        rdx(28'h0000010);
        check("forwarded data", 32'h00000022, rd);
        wr(PROT_CMD_IDX, 32'h00000011);
        wr(SYS_STATUS_IDX, 32'h00000000);
        st(1'b0, 1'b0);
        wr(PROT_CMD_IDX, 32'h00000011);
        wr(PROT_CMD_IDX, 32'h00000011);
        st(1'b0, 1'b1);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        do_reset();
        t_reset_vals();
        t_base_wait();
        t_extra_wait();
        t_good_seq();
        t_wrong_target();
        do_reset();
        st(1'b0, 1'b0);
        t_reset_vals();
        give_verdict();
    end

    // some forty accesses of at most some twenty-five cycles each
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fails++;
        give_verdict();
    end
endmodule

`default_nettype wire
